// ### verilog/cbd_cfg.svh
`ifndef CBD_CFG_SVH
`define CBD_CFG_SVH

// Command frame encodings
`define CBD_INIT_BC_READ    8'hC0
`define CBD_REQ_BC_READ     3'h4
`define CBD_REQ_BC_WRITE    3'h5
`define CBD_REQ_BC_REV      3'h6
`define CBD_LEN_FIXED       3'h0
`define CBD_FRAME_TYPE_BIT  7
// Chain control register
`define CBD_CHAIN_CTL_ADDR  16'h0309
`define CBD_CHAIN_CTL_RST   8'h00
`define CBD_DIR_SEL_BIT     7
// Register window held locally for reads and writes
`define CBD_REG_DEPTH       256
`define CBD_MAX_WRITE       8

`endif

// ### verilog/cbd_pkg.sv
package cbd_pkg;
	typedef enum logic [2:0] {
		CBD_IDLE  = 3'b000,
		CBD_ADRH  = 3'b001,
		CBD_ADRL  = 3'b011,
		CBD_DATA  = 3'b010,
		CBD_CRC0  = 3'b110,
		CBD_CRC1  = 3'b111,
		CBD_EXEC  = 3'b101
	} cbd_state_e;

	typedef enum logic [1:0] {
		CBD_CMD_READ  = 2'h0,
		CBD_CMD_WRITE = 2'h1,
		CBD_CMD_REV   = 2'h2
	} cbd_cmd_e;

	// Byte received from a chain port
	typedef struct packed {
		logic       valid;
		logic       sof;
		logic       upper;
		logic [7:0] data;
	} cbd_rx_s;

	// Byte handed to the response transmitter
	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} cbd_tx_s;
endpackage

// ### verilog/cbd_decode.sv
`include "cbd_cfg.svh"

module cbd_decode
	import cbd_pkg::*;
(
	// Clock and reset
	input  wire logic    mclk,
	input  wire logic    rstn,
	input  wire logic    clk_en,
	// Decoded bytes from the chain receivers
	input  wire cbd_rx_s rx,
	// Top of chain strap and upstream response seen
	input  wire logic    top_of_chain,
	input  wire logic    above_done,
	// Response bytes and line drive
	output cbd_tx_s      tx,
	output logic         upper_chain_port_p,
	output logic         upper_chain_port_n,
	output logic         lower_chain_port_p,
	output logic         lower_chain_port_n,
	// Status
	output logic         comm_err,
	output logic         dir_sel,
	output logic [7:0]   chain_ctl_one
);

	cbd_state_e       state;
	cbd_cmd_e         cmd;
	logic [2:0]       wr_left;
	logic [7:0]       rd_len;
	logic [15:0]      addr;
	logic [7:0]       regs [0:`CBD_REG_DEPTH-1];
	logic [7:0]       rd_ptr;
	logic [8:0]       rd_left;
	logic             rd_busy;
	logic             wr_en;
	logic [7:0]       wr_data;
	logic             wrong_port;

	// Port opposite direction select: 1 -> upper expected, 0 -> lower
	assign wrong_port = rx.upper ^ dir_sel;

	//--------------------------------------------------------------
	// Frame parser
	//--------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			state   <= CBD_IDLE;
			cmd     <= CBD_CMD_READ;
			wr_left <= 3'h0;
			rd_len  <= 8'h00;
			addr    <= 16'h0000;
		end
		else if (clk_en)
		begin
			if (rx.valid && rx.sof)
			begin
				state <= CBD_IDLE;
				if (rx.data[`CBD_FRAME_TYPE_BIT])
				begin
					unique case (rx.data[6:4])
					`CBD_REQ_BC_READ:
					begin
						// Data size field fixed at zero
						if (rx.data[2:0] == `CBD_LEN_FIXED && !wrong_port)
						begin
							cmd   <= CBD_CMD_READ;
							state <= CBD_ADRH;
						end
					end
					`CBD_REQ_BC_WRITE:
					begin
						if (!wrong_port)
						begin
							cmd     <= CBD_CMD_WRITE;
							wr_left <= rx.data[2:0];
							state   <= CBD_ADRH;
						end
					end
					`CBD_REQ_BC_REV:
					begin
						// Accepted only from the opposite side
						if (rx.data[2:0] == `CBD_LEN_FIXED && wrong_port)
						begin
							cmd     <= CBD_CMD_REV;
							wr_left <= 3'h0;
							state   <= CBD_ADRH;
						end
					end
					default:
						state <= CBD_IDLE;
					endcase
				end
			end
			else if (rx.valid)
			begin
				unique case (state)
				CBD_IDLE, CBD_EXEC:
					state <= CBD_IDLE;
				CBD_ADRH:
				begin
					addr[15:8] <= rx.data;
					state      <= CBD_ADRL;
				end
				CBD_ADRL:
				begin
					addr[7:0] <= rx.data;
					state     <= CBD_DATA;
				end
				CBD_DATA:
				begin
					if (cmd == CBD_CMD_READ)
					begin
						rd_len <= rx.data;
						state  <= CBD_CRC0;
					end
					else
					begin
						addr <= addr + 16'h0001;
						if (wr_left == 3'h0)
							state <= CBD_CRC0;
						else
							wr_left <= wr_left - 3'h1;
					end
				end
				CBD_CRC0:
					state <= CBD_CRC1;
				CBD_CRC1:
					state <= CBD_EXEC;
				endcase
			end
			else if (state == CBD_EXEC)
				state <= CBD_IDLE;
		end
	end

	//--------------------------------------------------------------
	// Communication error flag (no collision check exists)
	//--------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rstn)
			comm_err <= 1'b0;
		else if (clk_en && rx.valid && rx.sof && wrong_port
		         && rx.data[6:4] != `CBD_REQ_BC_REV)
			comm_err <= 1'b1;
	end

	//--------------------------------------------------------------
	// Register writes, including the chain control register
	//--------------------------------------------------------------
	assign wr_en   = rx.valid && !rx.sof && state == CBD_DATA
	                 && cmd != CBD_CMD_READ;
	assign wr_data = rx.data;

	always_ff @(posedge mclk)
	begin
		if (clk_en && wr_en)
			regs[addr[7:0]] <= wr_data;
	end

	always_ff @(posedge mclk)
	begin
		if (!rstn)
			chain_ctl_one <= `CBD_CHAIN_CTL_RST;
		else if (clk_en && wr_en && addr == `CBD_CHAIN_CTL_ADDR)
			chain_ctl_one <= wr_data;
	end

	assign dir_sel = chain_ctl_one[`CBD_DIR_SEL_BIT];

	//--------------------------------------------------------------
	// Broadcast read response, ordered down the chain
	//--------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			rd_busy <= 1'b0;
			rd_ptr  <= 8'h00;
			rd_left <= 9'h000;
			tx      <= '0;
		end
		else if (clk_en)
		begin
			tx.valid <= 1'b0;
			tx.last  <= 1'b0;
			if (state == CBD_EXEC && cmd == CBD_CMD_READ)
			begin
				rd_busy <= 1'b1;
				rd_ptr  <= addr[7:0];
				rd_left <= {1'b0, rd_len} + 9'h001;
			end
			else if (rd_busy && (top_of_chain || above_done))
			begin
				tx.valid <= 1'b1;
				tx.data  <= regs[rd_ptr];
				tx.last  <= rd_left == 9'h001;
				rd_ptr   <= rd_ptr + 8'h01;
				rd_left  <= rd_left - 9'h001;
				if (rd_left == 9'h001)
					rd_busy <= 1'b0;
			end
		end
	end

	//--------------------------------------------------------------
	// Differential line drive of the response bit
	//--------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			upper_chain_port_p <= 1'b0;
			upper_chain_port_n <= 1'b1;
			lower_chain_port_p <= 1'b0;
			lower_chain_port_n <= 1'b1;
		end
		else if (clk_en)
		begin
			upper_chain_port_p <= tx.data[0];
			upper_chain_port_n <= ~tx.data[0];
			lower_chain_port_p <= tx.data[0];
			lower_chain_port_n <= ~tx.data[0];
		end
	end

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	default clocking chk_clk @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	a_rev_needs_opposite: assert property (
		clk_en && rx.valid && rx.sof && rx.data == 8'hE0 && !wrong_port
		|=> state == CBD_IDLE)
		else $error("reverse write taken from expected port");
	a_wrong_port_err: assert property (
		clk_en && rx.valid && rx.sof && wrong_port && rx.data == 8'hC0
		|=> comm_err)
		else $error("wrong port frame not flagged");
	a_read_no_addr: assert property (
		clk_en && rx.valid && rx.sof && rx.data == 8'hC0 && !wrong_port
		|=> state == CBD_ADRH)
		else $error("broadcast read not started");
	a_write_count: assert property (
		clk_en && rx.valid && rx.sof && rx.data[7:4] == 4'hD && !wrong_port
		|=> wr_left == $past(rx.data[2:0]))
		else $error("write count wrong");
	a_rev_init: assert property (
		clk_en && rx.valid && rx.sof && rx.data == 8'hE0 && wrong_port
		|=> cmd == CBD_CMD_REV && wr_left == 3'h0)
		else $error("reverse write not decoded");
	a_dir_write: assert property (
		clk_en && wr_en && addr == 16'h0309
		|=> dir_sel == $past(wr_data[7]))
		else $error("direction select not updated");
	a_read_len: assert property (
		clk_en && state == CBD_EXEC && cmd == CBD_CMD_READ
		|=> rd_left == {1'b0, $past(rd_len)} + 9'h001)
		else $error("read length wrong");
	a_wait_above: assert property (
		clk_en && !top_of_chain && !above_done |=> !tx.valid)
		else $error("response before device above");
	a_diff_pair: assert property (
		upper_chain_port_p != upper_chain_port_n
		&& lower_chain_port_p != lower_chain_port_n)
		else $error("lines not complementary");
	a_addr_step: assert property (
		clk_en && wr_en |=> addr == $past(addr) + 16'h0001)
		else $error("address not advanced");

	c_read: cover property (state == CBD_EXEC && cmd == CBD_CMD_READ);
	c_write: cover property (state == CBD_EXEC && cmd == CBD_CMD_WRITE);
	c_rev: cover property (state == CBD_EXEC && cmd == CBD_CMD_REV);
	c_err: cover property ($rose(comm_err));

endmodule

// ### tb/cbd_host.sv
module cbd_host
	import cbd_pkg::*;
(
	// Clock
	input  wire logic mclk,
	// Frames toward the device
	output cbd_rx_s   rx,
	output logic      above_done
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		rx = '0;
		above_done = 1'b0;
	end

	// Device above finishes its answer at random moments
	always @(negedge mclk)
		above_done <= 1'($urandom_range(0, 1));

	// Init byte, address high and low, data, two check bytes
	task automatic send(input logic [7:0] ini, input logic [15:0] adr,
		input logic up, input int n, input logic [7:0] d [8]);
		logic [7:0] b [$];
		b = {ini, adr[15:8], adr[7:0]};
		for (int i = 0; i < n; i++)
			b.push_back(d[i]);
		b.push_back(8'($urandom));
		b.push_back(8'($urandom));
		foreach (b[i])
		begin
			@(negedge mclk);
			rx <= '{1'b1, i == 0, up, b[i]};
		end
		// Released byte lane shows the inverse, not the last value
		@(negedge mclk);
		rx <= '{1'b0, 1'b0, up, ~b[b.size() - 1]};
		repeat (3) @(negedge mclk);
	endtask
endmodule

// ### tb/testbench.sv
module testbench;
	import cbd_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic       mclk = 0, rstn = 0, clk_en = 1, top_of_chain = 0;
	logic       up_p, up_n, lo_p, lo_n, comm_err, dir_sel, above_done;
	logic [7:0] chain_ctl_one;
	cbd_rx_s    rx;
	cbd_tx_s    tx;
	int         mismatches = 0, check_count = 0, cycles = 0;
	logic [8:0] exp_q [$];
	logic [8:0] note;
	logic       line_bit = 1'b0, line_due = 1'b0;
	logic [7:0] mem [256];
	logic [7:0] d [8];

	always #20 mclk = ~mclk;

	cbd_host cbd_host_i (.mclk(mclk), .rx(rx), .above_done(above_done));

	cbd_decode cbd_decode_i (.mclk(mclk), .rstn(rstn), .clk_en(clk_en),
		.rx(rx), .top_of_chain(top_of_chain), .above_done(above_done),
		.tx(tx), .upper_chain_port_p(up_p), .upper_chain_port_n(up_n),
		.lower_chain_port_p(lo_p), .lower_chain_port_n(lo_n),
		.comm_err(comm_err), .dir_sel(dir_sel),
		.chain_ctl_one(chain_ctl_one));

	task automatic check(input string nm, input logic [8:0] e, g);
		check_count++;
		if (e !== g)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic up, input int n);
		for (int i = 0; i < n; i++)
		begin
			d[i] = 8'($urandom);
			mem[8'(a[7:0] + i)] = d[i];
		end
		cbd_host_i.send(8'hD0 | 8'(n - 1), a, up, n, d);
	endtask

	task automatic rd(input logic [15:0] a, input logic up, input int n);
		for (int i = 0; i <= n; i++)
			exp_q.push_back({i == n, mem[8'(a[7:0] + i)]});
		d[0] = 8'(n);
		cbd_host_i.send(8'hC0, a, up, 1, d);
		for (int i = 0; i < 400 && exp_q.size() != 0; i++)
			@(negedge mclk);
		repeat (4) @(negedge mclk);
		check("pending tx", 9'h0, 9'(exp_q.size()));
		exp_q.delete();
	endtask

	task automatic rev(input logic up);
		d[0] = 8'h80;
		cbd_host_i.send(8'hE0, 16'h0309, up, 1, d);
	endtask

	// Response watcher: each byte against the oldest note
	always @(posedge mclk)
	begin
		if (line_due)
			check("line bit", {7'h0, {2{line_bit}}},
				{7'h0, up_p, lo_p});
		line_due = 1'b0;
		if (rstn && tx.valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("extra tx byte", 9'h0, {tx.last, tx.data});
			else
			begin
				note = exp_q.pop_front();
				check("tx byte", note, {tx.last, tx.data});
				line_bit = note[0];
				line_due = 1'b1;
			end
		end
	end

	always @(posedge mclk)
	begin
		if (rstn === 1'b1)
			check("pairs", 9'h3, {7'h0, up_p ^ up_n, lo_p ^ lo_n});
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			wrap_up();
		end
	end

	initial
	begin
		void'($urandom(32'ha375));
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		rstn <= 1'b1;
		check("ctl reset", 9'h0, {1'b0, chain_ctl_one});
		check("line reset", 9'h1, {7'h0, lo_p, lo_n});
		for (int k = 0; k < 4; k++)
			wr(16'h0568 + 16'(8 * k), 1'b0, 8);
		rd(16'h0568, 1'b0, 8'h1F);
		$display("test read32 done");
		top_of_chain <= 1'b1;
		wr(16'h00FF, 1'b0, 2);
		rd(16'h00FF, 1'b0, 1);
		$display("test top wrap done");
		rev(1'b0);
		check("rev ignored", 9'h0, {1'b0, chain_ctl_one});
		check("no err", 9'h0, {8'h0, comm_err});
		rev(1'b1);
		check("rev ctl", 9'h080, {1'b0, chain_ctl_one});
		check("dir", 9'h1, {8'h0, dir_sel});
		wr(16'h0020, 1'b1, 3);
		rd(16'h0020, 1'b1, 2);
		check("no err up", 9'h0, {8'h0, comm_err});
		$display("test reverse done");
		clk_en <= 1'b0;
		d[0] = 8'h00;
		cbd_host_i.send(8'hD0, 16'h0309, 1'b1, 1, d);
		check("frozen ctl", 9'h080, {1'b0, chain_ctl_one});
		clk_en <= 1'b1;
		$display("test clock enable done");
		d[0] = 8'h00;
		cbd_host_i.send(8'hC0, 16'h0020, 1'b0, 1, d);
		repeat (40) @(negedge mclk);
		check("wrong port", 9'h1, {8'h0, comm_err});
		$display("test wrong port done");
		wrap_up();
	end
endmodule
